// ==== design/ssqh_pkg.sv ====
package ssqh_pkg;

	// ----------------------------------------
	// Frame codes
	// ----------------------------------------
	localparam logic [7:0]  FC_DIAG      = 8'h08;
	localparam logic [7:0]  FC_FORCE     = 8'h0f;
	localparam logic [7:0]  FC_PRESET    = 8'h10;
	localparam logic [7:0]  FC_DEVTYPE   = 8'h11;
	localparam logic [7:0]  FC_MASKWR    = 8'h16;
	localparam logic [7:0]  FC_ERR_FLAG  = 8'h80;
	localparam logic [15:0] DG_ECHO      = 16'h0000;
	localparam logic [15:0] DG_RESTART   = 16'h0001;
	localparam logic [15:0] DG_LISTEN    = 16'h0004;
	localparam logic [7:0]  RESTART_ALT  = 8'hff;
	localparam logic [7:0]  SUB_ADDR     = 8'h02;
	localparam logic [7:0]  SUB_DATA     = 8'h03;
	localparam logic [7:0]  BCAST_ADDR   = 8'h00;
	localparam logic [7:0]  DEVTYPE_BC   = 8'h05;
	localparam logic [7:0]  RUN_ON       = 8'hff;
	localparam logic [15:0] REG_CNT_MAX  = 16'h007d;

	// ----------------------------------------
	// Frame sizes; query sizes include the CRC bytes, reply sizes exclude them
	// ----------------------------------------
	localparam int          BUF_DEPTH    = 265;
	localparam logic [8:0]  LEN_MIN      = 9'h004;
	localparam logic [8:0]  LEN_DIAG     = 9'h008;
	localparam logic [8:0]  LEN_DEVTYPE  = 9'h004;
	localparam logic [8:0]  LEN_MASKWR   = 9'h00a;
	localparam logic [8:0]  LEN_WR_HDR   = 9'h009;
	localparam logic [8:0]  DATA_OFS     = 9'h007;
	localparam logic [3:0]  RSP_ECHO     = 4'h6;
	localparam logic [3:0]  RSP_LONG     = 4'h8;
	localparam logic [3:0]  RSP_ERR      = 4'h3;

	// ----------------------------------------
	// CRC
	// ----------------------------------------
	localparam logic [15:0] CRC_INIT     = 16'hffff;
	localparam logic [15:0] CRC_POLY     = 16'ha001;

	typedef enum logic [7:0] {
		S_RX     = 8'b0000_0001,
		S_CHECK  = 8'b0000_0010,
		S_FORCE  = 8'b0000_0100,
		S_PRESET = 8'b0000_1000,
		S_MRD    = 8'b0001_0000,
		S_MWR    = 8'b0010_0000,
		S_CRC    = 8'b0100_0000,
		S_SEND   = 8'b1000_0000
	} ssqh_state_t;

	typedef struct packed {
		ssqh_state_t       st;
		logic [8:0]        len;
		logic              ovf;
		logic              listen;
		logic [15:0]       idx;
		logic [15:0]       start;
		logic [15:0]       count;
		logic [7:0][7:0]   resp;
		logic [3:0]        resp_len;
		logic              reply;
		logic              coil_we;
		logic [15:0]       coil_addr;
		logic              coil_val;
		logic              reg_we;
		logic              reg_re;
		logic [15:0]       reg_addr;
		logic [15:0]       reg_wdata;
		logic              tx_valid;
		logic [7:0]        tx_byte;
		logic              tx_last;
	} ssqh_regs_t;

	typedef struct packed {
		logic [15:0] crc;
	} ssqh_crc_regs_t;

endpackage

// ==== design/ssqh_crc_if.sv ====
`timescale 1ns/10ps
interface ssqh_crc_if;
	logic        clr;
	logic        en;
	logic [7:0]  data;
	logic [15:0] crc;

	modport user (output clr, output en, output data, input crc);
	modport calc (input clr, input en, input data, output crc);
endinterface

// ==== design/ssqh_crc16.sv ====
`timescale 1ns/10ps
module ssqh_crc16 (
	input  wire logic  clk,
	input  wire logic  rst_n,
	ssqh_crc_if.calc   c
);
	import ssqh_pkg::*;

	ssqh_crc_regs_t q;
	ssqh_crc_regs_t d;

	function automatic logic [15:0] crc_step(input logic [15:0] cin, input logic [7:0] b);
		logic [15:0] x;
		x = cin ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction

	always_comb begin
		d = q;
		if (c.clr) begin
			d.crc = CRC_INIT;
		end else if (c.en) begin
			d.crc = crc_step(q.crc, c.data);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{crc: CRC_INIT};
		end else begin
			q <= d;
		end
	end

	assign c.crc = q.crc;
endmodule

// ==== design/ssqh_handler.sv ====
`timescale 1ns/10ps
module ssqh_handler #(
	parameter logic [7:0] DEVICE_TYPE = 8'h5a, // Arbitrary value
	parameter logic [7:0] MINOR_TYPE  = 8'h01  // Arbitrary value
) (
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic [7:0]  STATION_ADDR,
	input  wire logic        RUN_MODE,
	input  wire logic [15:0] MAX_COILS,
	input  wire logic [15:0] MAX_REGS,
	input  wire logic [7:0]  RX_BYTE,
	input  wire logic        RX_VALID,
	input  wire logic        RX_END,
	output logic      [7:0]  TX_BYTE,
	output logic             TX_VALID,
	input  wire logic        TX_READY,
	output logic             TX_LAST,
	output logic             COIL_WE,
	output logic      [15:0] COIL_ADDR,
	output logic             COIL_VALUE,
	output logic             REG_WE,
	output logic             REG_RE,
	output logic      [15:0] REG_ADDR,
	output logic      [15:0] REG_WDATA,
	input  wire logic [15:0] REG_RDATA,
	output logic             LISTEN_ONLY,
	output logic             BUSY
);
	import ssqh_pkg::*;

	ssqh_regs_t  q;
	ssqh_regs_t  n;
	logic [7:0]  fbuf [BUF_DEPTH];

	ssqh_crc_if  rxc ();
	ssqh_crc_if  txc ();

	ssqh_crc16 u_rx_crc (
		.clk   (CLK),
		.rst_n (RESETN),
		.c     (rxc.calc)
	);

	ssqh_crc16 u_tx_crc (
		.clk   (CLK),
		.rst_n (RESETN),
		.c     (txc.calc)
	);

	// ----------------------------------------
	// Frame buffer
	// ----------------------------------------
	logic rx_take;
	assign rx_take = (q.st == S_RX) && RX_VALID && (q.len < 9'(BUF_DEPTH));

	always_ff @(posedge CLK) begin
		if (rx_take) begin
			fbuf[q.len] <= RX_BYTE;
		end
	end

	function automatic logic [7:0] rb(input logic [8:0] i);
		return fbuf[i];
	endfunction

	function automatic logic [15:0] rw(input logic [8:0] i);
		return {fbuf[i], fbuf[i + 9'h001]};
	endfunction

	// Whole-frame CRC including its own two bytes leaves zero
	assign rxc.clr  = (q.st != S_RX);
	assign rxc.en   = rx_take;
	assign rxc.data = RX_BYTE;

	assign txc.clr  = (q.st == S_CHECK);
	assign txc.en   = (q.st == S_CRC);
	assign txc.data = q.resp[q.idx[2:0]];

	// ----------------------------------------
	// Query fields
	// ----------------------------------------
	logic [7:0]  f_addr;
	logic [7:0]  f_fc;
	logic [15:0] f_w2;
	logic [15:0] f_w4;
	logic [7:0]  f_bc;
	logic [8:0]  bc_full;
	logic        mine;
	logic        bcast;
	logic        crc_ok;

	always_comb begin
		f_addr  = rb(9'h000);
		f_fc    = rb(9'h001);
		f_w2    = rw(9'h002);
		f_w4    = rw(9'h004);
		f_bc    = rb(9'h006);
		bc_full = (f_bc == 8'h00) ? 9'h100 : {1'b0, f_bc};
		mine    = (f_addr == STATION_ADDR);
		bcast   = (f_addr == BCAST_ADDR);
		crc_ok  = (rxc.crc == 16'h0000) && !q.ovf && (q.len >= LEN_MIN);
	end

	function automatic logic [7:0] tx_pick(input logic [15:0] i, input ssqh_regs_t s, input logic [15:0] c);
		if (i < {12'h000, s.resp_len}) begin
			return s.resp[i[2:0]];
		end else if (i == {12'h000, s.resp_len}) begin
			return c[7:0];
		end else begin
			return c[15:8];
		end
	endfunction

	// ----------------------------------------
	// Control
	// ----------------------------------------
	always_comb begin
		logic [16:0] span;
		logic [15:0] pos;
		logic [8:0]  bidx;
		span = 17'h00000;
		pos  = 16'h0000;
		bidx = 9'h000;
		n    = q;
		n.coil_we = 1'b0;
		n.reg_we  = 1'b0;
		n.reg_re  = 1'b0;
		case (q.st)
			S_RX: begin
				if (rx_take) begin
					n.len = q.len + 9'h001;
				end else if (RX_VALID) begin
					n.ovf = 1'b1;
				end
				if (RX_END) begin
					n.st = S_CHECK;
				end
			end
			S_CHECK: begin
				n.st       = S_RX;
				n.len      = 9'h000;
				n.ovf      = 1'b0;
				n.idx      = 16'h0000;
				n.start    = f_w2;
				n.count    = f_w4;
				n.reply    = mine;
				n.resp_len = RSP_ECHO;
				for (int k = 0; k < 8; k++) begin
					n.resp[k] = rb(9'(k));
				end
				if (crc_ok && (mine || bcast)) begin
					if (f_fc == FC_DIAG && q.len == LEN_DIAG) begin
						if (f_w2 == DG_RESTART) begin
							if (rb(9'h004) != 8'h00 && rb(9'h004) != RESTART_ALT) begin
								if (mine && !q.listen) begin
									n.resp[1]  = f_fc | FC_ERR_FLAG;
									n.resp[2]  = SUB_DATA;
									n.resp_len = RSP_ERR;
									n.st       = S_CRC;
								end
							end else begin
								n.listen = 1'b0;
								if (mine) begin
									n.st = S_CRC;
								end
							end
						end else if (f_w2 == DG_LISTEN) begin
							if (!q.listen) begin
								n.listen = 1'b1;
							end
						end else if (!q.listen && mine) begin
							if (f_w2 == DG_ECHO) begin
								n.st = S_CRC;
							end else begin
								n.resp[1]  = f_fc | FC_ERR_FLAG;
								n.resp[2]  = SUB_ADDR;
								n.resp_len = RSP_ERR;
								n.st       = S_CRC;
							end
						end
					end else if (!q.listen) begin
						n.resp[1] = f_fc | FC_ERR_FLAG;
						n.resp_len = RSP_ERR;
						span = {1'b0, f_w2} + {1'b0, f_w4};
						case (f_fc)
							FC_FORCE: begin
								if (q.len == LEN_WR_HDR + bc_full) begin
									if (f_w4 == 16'h0000 || span > {1'b0, MAX_COILS}) begin
										n.resp[2] = SUB_ADDR;
										n.st      = mine ? S_CRC : S_RX;
									end else if ({7'h00, bc_full} != ((f_w4 + 16'h0007) >> 3)) begin
										n.resp[2] = SUB_DATA;
										n.st      = mine ? S_CRC : S_RX;
									end else begin
										n.resp_len = RSP_ECHO;
										n.resp[1]  = f_fc;
										n.st       = S_FORCE;
									end
								end
							end
							FC_PRESET: begin
								if (q.len == LEN_WR_HDR + {1'b0, f_bc}) begin
									if (f_w4 == 16'h0000 || f_w4 > REG_CNT_MAX
											|| {8'h00, f_bc} != {f_w4[14:0], 1'b0}) begin
										n.resp[2] = SUB_DATA;
										n.st      = mine ? S_CRC : S_RX;
									end else if (span > {1'b0, MAX_REGS}) begin
										n.resp[2] = SUB_ADDR;
										n.st      = mine ? S_CRC : S_RX;
									end else begin
										n.resp_len = RSP_ECHO;
										n.resp[1]  = f_fc;
										n.st       = S_PRESET;
									end
								end
							end
							FC_DEVTYPE: begin
								if (mine && q.len == LEN_DEVTYPE) begin
									n.resp[1]  = f_fc;
									n.resp[2]  = DEVTYPE_BC;
									n.resp[3]  = DEVICE_TYPE;
									n.resp[4]  = RUN_MODE ? RUN_ON : 8'h00;
									n.resp[5]  = MINOR_TYPE;
									n.resp[6]  = 8'h00;
									n.resp[7]  = 8'h00;
									n.resp_len = RSP_LONG;
									n.st       = S_CRC;
								end
							end
							FC_MASKWR: begin
								if (mine && q.len == LEN_MASKWR) begin
									if (f_w2 >= MAX_REGS) begin
										n.resp[2] = SUB_ADDR;
										n.st      = S_CRC;
									end else begin
										n.resp[1]  = f_fc;
										n.resp_len = RSP_LONG;
										n.st       = S_MRD;
									end
								end
							end
							default: begin
								n.st = S_RX;
							end
						endcase
					end
				end
			end
			S_FORCE: begin
				pos = q.idx;
				bidx = DATA_OFS + 9'(pos[15:3]);
				n.coil_we   = 1'b1;
				n.coil_addr = q.start + pos;
				n.coil_val  = fbuf[bidx][pos[2:0]];
				n.idx       = q.idx + 16'h0001;
				if (q.idx == q.count - 16'h0001) begin
					n.idx = 16'h0000;
					n.st  = q.reply ? S_CRC : S_RX;
				end
			end
			S_PRESET: begin
				bidx = DATA_OFS + 9'({q.idx[7:0], 1'b0});
				n.reg_we    = 1'b1;
				n.reg_addr  = q.start + q.idx;
				n.reg_wdata = rw(bidx);
				n.idx       = q.idx + 16'h0001;
				if (q.idx == q.count - 16'h0001) begin
					n.idx = 16'h0000;
					n.st  = q.reply ? S_CRC : S_RX;
				end
			end
			S_MRD: begin
				n.reg_re   = 1'b1;
				n.reg_addr = q.start;
				n.st       = S_MWR;
			end
			S_MWR: begin
				// Read data is valid while REG_RE is high
				n.reg_we    = 1'b1;
				n.reg_wdata = (REG_RDATA & q.count) | ({q.resp[6], q.resp[7]} & q.count);
				n.st        = S_CRC;
			end
			S_CRC: begin
				n.idx = q.idx + 16'h0001;
				if (q.idx == {12'h000, q.resp_len} - 16'h0001) begin
					n.idx      = 16'h0000;
					n.tx_valid = 1'b1;
					n.tx_byte  = q.resp[0];
					n.tx_last  = 1'b0;
					n.st       = S_SEND;
				end
			end
			S_SEND: begin
				if (TX_READY) begin
					n.idx     = q.idx + 16'h0001;
					n.tx_byte = tx_pick(q.idx + 16'h0001, q, txc.crc);
					n.tx_last = (q.idx == {12'h000, q.resp_len});
					if (q.tx_last) begin
						n.tx_valid = 1'b0;
						n.tx_last  = 1'b0;
						n.idx      = 16'h0000;
						n.st       = S_RX;
					end
				end
			end
			default: begin
				n.st = S_RX;
			end
		endcase
	end

	// Power-up always leaves listen-only clear
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			q <= '{st: S_RX, default: '0};
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign TX_BYTE     = q.tx_byte;
	assign TX_VALID    = q.tx_valid;
	assign TX_LAST     = q.tx_last;
	assign COIL_WE     = q.coil_we;
	assign COIL_ADDR   = q.coil_addr;
	assign COIL_VALUE  = q.coil_val;
	assign REG_WE      = q.reg_we;
	assign REG_RE      = q.reg_re;
	assign REG_ADDR    = q.reg_addr;
	assign REG_WDATA   = q.reg_wdata;
	assign LISTEN_ONLY = q.listen;
	// Last write strobe trails the state change, so it still counts as busy
	assign BUSY        = (q.st != S_RX) || q.coil_we || q.reg_we;
endmodule

// ==== test/ssqh_master.sv ====
`timescale 1ns/10ps
module ssqh_master (
	input  wire logic       clk,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_valid,
	output logic      [7:0] rx_byte,
	output logic            rx_valid,
	output logic            rx_end,
	output logic            tx_ready
);
	logic [7:0] fr[$];
	logic [7:0] got[$];
	int         slow;
	initial begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		rx_end = 1'b0;
		tx_ready = 1'b1;
		slow = 0;
	end
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction
	// Random stalls when slow, so held bytes get tested
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_byte);
		#1 tx_ready <= (slow == 0) || ($urandom % 3 == 0);
	end
	// ----------------------------------------
	// Frame out, CRC low byte first
	// ----------------------------------------
	task automatic send(input logic bad);
		logic [15:0] c;
		c = crc(fr) ^ {15'h0000, bad};
		fr.push_back(c[7:0]);
		fr.push_back(c[15:8]);
		got.delete();
		foreach (fr[i]) begin
			rx_byte = fr[i];
			rx_valid = 1'b1;
			@(posedge clk) #1;
		end
		rx_valid = 1'b0;
		rx_byte = ~rx_byte;
		rx_end = 1'b1;
		@(posedge clk) #1;
		rx_end = 1'b0;
	endtask
endmodule

// ==== test/ssqh_handler_chk.sv ====
`timescale 1ns/10ps
module ssqh_handler_chk (
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic [15:0] MAX_COILS,
	input wire logic [15:0] MAX_REGS,
	input wire logic        RX_END,
	input wire logic [7:0]  TX_BYTE,
	input wire logic        TX_VALID,
	input wire logic        TX_READY,
	input wire logic        TX_LAST,
	input wire logic        COIL_WE,
	input wire logic [15:0] COIL_ADDR,
	input wire logic        REG_WE,
	input wire logic        REG_RE,
	input wire logic [15:0] REG_ADDR,
	input wire logic        LISTEN_ONLY,
	input wire logic        BUSY
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	sequence coil_run;
		COIL_WE ##1 COIL_WE;
	endsequence
	sequence rmw;
		REG_RE ##1 (REG_WE && REG_ADDR == $past(REG_ADDR));
	endsequence
	tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE) && $stable(TX_LAST))
		else $error("reply byte changed before accept");
	tx_end_a: assert property (TX_VALID && TX_READY && TX_LAST |=> !TX_VALID)
		else $error("reply goes on after last byte");
	listen_mute_a: assert property (LISTEN_ONLY |-> !TX_VALID)
		else $error("reply while listening only");
	listen_exec_a: assert property (LISTEN_ONLY |-> !COIL_WE && !REG_WE)
		else $error("write while listening only");
	coil_order_a: assert property (coil_run |-> COIL_ADDR == $past(COIL_ADDR) + 16'h0001)
		else $error("outputs not in ascending order");
	coil_range_a: assert property (COIL_WE |-> COIL_ADDR < MAX_COILS)
		else $error("output write out of range");
	reg_range_a: assert property (REG_WE |-> REG_ADDR < MAX_REGS)
		else $error("register write out of range");
	mask_step_a: assert property (REG_RE |-> rmw)
		else $error("masked write does not follow its read");
	frame_check_a: assert property (RX_END && !BUSY |=> BUSY)
		else $error("frame end not checked");
	write_first_a: assert property (COIL_WE || REG_WE |-> BUSY && !TX_VALID)
		else $error("write overlaps reply");
endmodule
bind ssqh_handler ssqh_handler_chk i_chk (.*);

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	import ssqh_pkg::*;
	localparam logic [7:0]  ME = 8'h21;
	localparam logic [7:0]  DT = 8'h3c; // Arbitrary value
	localparam logic [7:0]  MT = 8'h07; // Arbitrary value
	localparam logic [15:0] NC = 16'h0040;
	localparam logic [15:0] NR = 16'h0020;
	logic        CLK, RESETN, RUN_MODE, RX_VALID, RX_END, TX_READY, TX_VALID, TX_LAST;
	logic        COIL_WE, COIL_VALUE, REG_WE, REG_RE, LISTEN_ONLY, BUSY;
	logic [7:0]  RX_BYTE, TX_BYTE, a, b;
	logic [15:0] COIL_ADDR, REG_ADDR, REG_WDATA, REG_RDATA, d, m1, m2;
	logic [7:0]  ex[$];
	logic [31:0] wr[$], ew[$];
	int          num_errors, n_compared, n, s;
	ssqh_handler #(.DEVICE_TYPE(DT), .MINOR_TYPE(MT)) i_ssqh_handler (
		.CLK(CLK), .RESETN(RESETN), .STATION_ADDR(ME), .RUN_MODE(RUN_MODE), .MAX_COILS(NC),
		.MAX_REGS(NR), .RX_BYTE(RX_BYTE), .RX_VALID(RX_VALID), .RX_END(RX_END), .TX_BYTE(TX_BYTE),
		.TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_LAST(TX_LAST), .COIL_WE(COIL_WE),
		.COIL_ADDR(COIL_ADDR), .COIL_VALUE(COIL_VALUE), .REG_WE(REG_WE), .REG_RE(REG_RE),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.LISTEN_ONLY(LISTEN_ONLY), .BUSY(BUSY));
	ssqh_master i_ssqh_master (.clk(CLK), .tx_byte(TX_BYTE), .tx_valid(TX_VALID), .rx_byte(RX_BYTE),
		.rx_valid(RX_VALID), .rx_end(RX_END), .tx_ready(TX_READY));
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		if (COIL_WE)
			wr.push_back({15'h0000, COIL_VALUE, COIL_ADDR});
		if (REG_WE)
			wr.push_back({REG_WDATA, REG_ADDR});
	end
	// ----------------------------------------
	// Checks and closing
	// ----------------------------------------
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic conclude();
		$display("%0d compared, %0d errors", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Reply bytes, CRC added here from the model
	task automatic cmp_rsp();
		logic [15:0] c;
		if (ex.size() != 0) begin
			c = i_ssqh_master.crc(ex);
			ex.push_back(c[7:0]);
			ex.push_back(c[15:8]);
		end
		cmp(i_ssqh_master.got.size(), ex.size(), "reply length");
		foreach (ex[i])
			if (i < i_ssqh_master.got.size())
				cmp(i_ssqh_master.got[i], ex[i], "reply byte");
	endtask
	task automatic cmp_wr();
		cmp(wr.size(), ew.size(), "write count");
		foreach (ew[i])
			if (i < wr.size())
				cmp(wr[i], ew[i], "write");
	endtask
	// One query: expected reply in ex and writes in ew beforehand
	task automatic xact(input logic bad, input string name);
		int k;
		wr.delete();
		i_ssqh_master.send(bad);
		k = 0;
		while (BUSY !== 1'b0 && k < 3000) begin
			@(posedge CLK) #1;
			k++;
		end
		if (BUSY !== 1'b0) begin
			num_errors++;
			$display("BAD %0t %s hangs", $time, name);
			conclude();
		end
		#1;
		cmp_rsp();
		cmp_wr();
		ex.delete();
		ew.delete();
		$display("%s done", name);
	endtask
	initial begin
		num_errors = 0;
		n_compared = 0;
		RESETN = 1'b0;
		RUN_MODE = 1'b1;
		REG_RDATA = 16'h0000;
		void'($urandom(32'hfa70));
		repeat (2) @(posedge CLK);
		#1 RESETN = 1'b1;
		cmp(LISTEN_ONLY, 1'b0, "listen after reset");
		a = 8'($urandom);
		b = 8'($urandom);
		i_ssqh_master.fr = '{ME, FC_DIAG, 8'h00, 8'h00, a, b};
		ex = i_ssqh_master.fr;
		xact(1'b0, "echo");
		i_ssqh_master.fr = '{ME, FC_DIAG, 8'h00, 8'h00, a, b};
		xact(1'b1, "bad crc");
		for (int i = 0; i < 2; i++) begin
			d = i ? 16'h0100 : 16'h0002;
			i_ssqh_master.fr = '{ME, FC_DIAG, d[15:8], d[7:0], 8'h00, 8'h00};
			ex = '{ME, FC_DIAG | FC_ERR_FLAG, SUB_ADDR};
			xact(1'b0, "reserved code");
		end
		i_ssqh_master.fr = '{ME, FC_DIAG, 8'h00, 8'h01, 8'h12, 8'h00};
		ex = '{ME, FC_DIAG | FC_ERR_FLAG, SUB_DATA};
		xact(1'b0, "restart bad data");
		i_ssqh_master.slow = 1;
		for (s = 0; s < 2; s++) begin
			i_ssqh_master.fr = '{s ? BCAST_ADDR : ME, FC_DIAG, 8'h00, 8'h04, 8'h00, 8'h00};
			xact(1'b0, "listen only");
			cmp(LISTEN_ONLY, 1'b1, "listen set");
			i_ssqh_master.fr = '{ME, FC_FORCE, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
			xact(1'b0, "muted force");
			i_ssqh_master.fr = '{s ? BCAST_ADDR : ME, FC_DIAG, 8'h00, 8'h01, s ? 8'h00 : 8'hff, 8'h00};
			if (!s)
				ex = i_ssqh_master.fr;
			xact(1'b0, "restart");
			cmp(LISTEN_ONLY, 1'b0, "listen cleared");
		end
		for (s = 0; s < 2; s++) begin
			n = 1 + $urandom % 16;
			d = 16'($urandom) & ((16'h1 << n) - 16'h1);
			a = 8'($urandom % 40);
			i_ssqh_master.fr = '{s ? BCAST_ADDR : ME, FC_FORCE, 8'h00, a, 8'h00, n[7:0], n > 8 ? 8'h02 : 8'h01};
			i_ssqh_master.fr.push_back(d[7:0]);
			if (n > 8)
				i_ssqh_master.fr.push_back(d[15:8]);
			for (int i = 0; i < n; i++)
				ew.push_back({15'h0000, d[i], 8'h00, a + i[7:0]});
			if (!s)
				ex = '{ME, FC_FORCE, 8'h00, a, 8'h00, n[7:0]};
			xact(1'b0, "force outputs");
		end
		for (s = 0; s < 2; s++) begin
			n = 1 + $urandom % 4;
			a = 8'($urandom % 16);
			i_ssqh_master.fr = '{s ? BCAST_ADDR : ME, FC_PRESET, 8'h00, a, 8'h00, n[7:0], 8'(2 * n)};
			for (int i = 0; i < n; i++) begin
				d = 16'($urandom);
				i_ssqh_master.fr.push_back(d[15:8]);
				i_ssqh_master.fr.push_back(d[7:0]);
				ew.push_back({d, 8'h00, a + i[7:0]});
			end
			if (!s)
				ex = '{ME, FC_PRESET, 8'h00, a, 8'h00, n[7:0]};
			xact(1'b0, "preset registers");
		end
		i_ssqh_master.fr = '{ME, FC_PRESET, 8'h00, 8'h1f, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02};
		ex = '{ME, FC_PRESET | FC_ERR_FLAG, SUB_ADDR};
		xact(1'b0, "preset range");
		i_ssqh_master.fr = '{ME, FC_PRESET, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h00, 8'h01};
		ex = '{ME, FC_PRESET | FC_ERR_FLAG, SUB_DATA};
		xact(1'b0, "preset count");
		i_ssqh_master.fr = '{ME, FC_FORCE, 8'h00, 8'h00, 8'h00, 8'h09, 8'h01, 8'h01};
		ex = '{ME, FC_FORCE | FC_ERR_FLAG, SUB_DATA};
		xact(1'b0, "force count");
		i_ssqh_master.fr = '{ME, FC_MASKWR, 8'h00, 8'h20, 8'hff, 8'hff, 8'h00, 8'h00};
		ex = '{ME, FC_MASKWR | FC_ERR_FLAG, SUB_ADDR};
		xact(1'b0, "mask range");
		for (s = 0; s < 2; s++) begin
			RUN_MODE = s[0];
			i_ssqh_master.fr = '{ME, FC_DEVTYPE};
			ex = '{ME, FC_DEVTYPE, 8'h05, DT, s ? 8'hff : 8'h00, MT, 8'h00, 8'h00};
			xact(1'b0, "device type");
		end
		REG_RDATA = 16'($urandom);
		m1 = 16'($urandom);
		m2 = 16'($urandom);
		a = 8'($urandom % 32);
		i_ssqh_master.fr = '{ME, FC_MASKWR, 8'h00, a, m1[15:8], m1[7:0], m2[15:8], m2[7:0]};
		ex = i_ssqh_master.fr;
		ew.push_back({(REG_RDATA & m1) | (m2 & m1), 8'h00, a});
		xact(1'b0, "mask write");
		conclude();
	end
endmodule
